/* File: hw/cmi_pkg.sv */
package cmi_pkg;
    // register word offsets, byte addresses on the bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] IF1_REQ_OFF = 8'h20;
    localparam logic [7:0] IF1_SEL_OFF = 8'h24;
    localparam logic [7:0] IF2_REQ_OFF = 8'h80;
    localparam logic [7:0] IF2_SEL_OFF = 8'h84;

    // transfer request register layout and reset value
    localparam int BUSY_BIT = 15;
    localparam int MSG_NUM_W = 6;
    localparam logic [5:0] MSG_NUM_RST = 6'h01;
    localparam logic [5:0] OBJ_LAST = 6'h20;

    // transfer select register layout and reset value
    localparam int SEL_W = 8;
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam int DIR_BIT = 7;
    localparam int FILTER_BIT = 6;
    localparam int ARB_BIT = 5;
    localparam int CTRL_BIT = 4;
    localparam int CLEAR_PENDING_BIT = 3;
    localparam int SEND_REQUEST_BIT = 2;
    localparam int LOW_PAYLOAD_BIT = 1;
    localparam int HIGH_PAYLOAD_BIT = 0;

    // busy time in bus clock periods, fixed inside the allowed window
    localparam int XFER_MIN_CYCLES = 3;
    localparam int XFER_MAX_CYCLES = 6;
    localparam int XFER_CYCLES = 4;
    localparam int CNT_W = 3;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic [5:0] msg_num;
        logic [7:0] select;
        logic busy;
        logic [2:0] count;
    } cmi_set_s;
endpackage : cmi_pkg

/* File: hw/cmi_transfer.sv */
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module cmi_transfer (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    output logic XFER_STB,
    output logic XFER_SET,
    output logic [5:0] XFER_OBJ,
    output logic [7:0] XFER_SELECT,
    output logic [1:0] XFER_DONE
);

    typedef struct packed {
        cmi_pkg::cmi_set_s [1:0] sets;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic xfer_stb;
        logic xfer_set;
        logic [5:0] xfer_obj;
        logic [7:0] xfer_select;
        logic [1:0] xfer_done;
    } cmi_state_s;

    cmi_state_s state_reg;
    cmi_state_s state_next;
    logic rst_meta_reg;
    logic rst_n_reg;
    logic [7:0] wr_word;
    logic [7:0] rd_word;
    logic [1:0] req_hit;
    logic [1:0] sel_hit;
    logic [1:0] req_start;

    // request register offset of one set
    function automatic logic [7:0] req_off(input int idx);
        req_off = (idx == 0) ? cmi_pkg::IF1_REQ_OFF : cmi_pkg::IF2_REQ_OFF;
    endfunction : req_off

    // select register offset of one set
    function automatic logic [7:0] sel_off(input int idx);
        sel_off = (idx == 0) ? cmi_pkg::IF1_SEL_OFF : cmi_pkg::IF2_SEL_OFF;
    endfunction : sel_off

    // invalid numbers are folded, never refused
    function automatic logic [5:0] map_obj(input logic [5:0] num);
        if (num == 6'h00) begin
            map_obj = cmi_pkg::OBJ_LAST;
        end else if (num > cmi_pkg::OBJ_LAST) begin
            // 0x21..0x3f less 0x20 lands on 0x01..0x1f
            map_obj = num - cmi_pkg::OBJ_LAST;
        end else begin
            map_obj = num;
        end
    endfunction : map_obj

    // reset release through two flops
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // word-aligned decode; low address bits ignored
    assign wr_word = {AWADDR[7:2], 2'b00};
    assign rd_word = {ARADDR[7:2], 2'b00};

    // per-set decode of the accepted write
    for (genvar g = 0; g < 2; g++) begin : g_hit
        assign req_hit[g] = state_reg.awready && (wr_word == req_off(g));
        assign sel_hit[g] = state_reg.awready && (wr_word == sel_off(g));
        // a write while busy is dropped so a live transfer is never corrupted
        assign req_start[g] = req_hit[g] && WSTRB[0] && !state_reg.sets[g].busy;
    end

    // next-state logic for bus slave and both interface sets
    always_comb begin
        state_next = state_reg;
        state_next.xfer_stb = 1'b0;
        state_next.xfer_done = 2'b00;

        // busy countdown, each set on its own
        // count loads one short, so busy stands XFER_CYCLES cycles in all
        for (int i = 0; i < 2; i++) begin
            if (state_reg.sets[i].busy) begin
                if (state_reg.sets[i].count == '0) begin
                    state_next.sets[i].busy = 1'b0;
                    state_next.xfer_done[i] = 1'b1;
                end else begin
                    state_next.sets[i].count = state_reg.sets[i].count - 3'h1;
                end
            end
        end

        // write path: both channels taken in one edge, then response
        // a lone address or lone data word simply waits for its partner
        if (!state_reg.awready && !state_reg.bvalid && AWVALID && WVALID) begin
            state_next.awready = 1'b1;
            state_next.wready = 1'b1;
        end
        if (state_reg.awready) begin
            state_next.awready = 1'b0;
            state_next.wready = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = ((req_hit | sel_hit) != 2'b00) ?
                cmi_pkg::RESP_OKAY : cmi_pkg::RESP_SLVERR;
            for (int i = 0; i < 2; i++) begin
                if (req_start[i]) begin
                    state_next.sets[i].msg_num = WDATA[5:0];
                    state_next.sets[i].busy = 1'b1;
                    state_next.sets[i].count = 3'(cmi_pkg::XFER_CYCLES - 1);
                    state_next.xfer_stb = 1'b1;
                    state_next.xfer_set = 1'(i);
                    state_next.xfer_obj = map_obj(WDATA[5:0]);
                    // direction and part selects travel with the strobe
                    state_next.xfer_select = state_reg.sets[i].select;
                end
                if (sel_hit[i] && WSTRB[0] && !state_reg.sets[i].busy) begin
                    state_next.sets[i].select = WDATA[7:0];
                end
            end
        end
        if (state_reg.bvalid && BREADY) begin
            state_next.bvalid = 1'b0;
        end

        // read path: address taken, data one cycle later
        if (!state_reg.arready && !state_reg.rvalid && ARVALID) begin
            state_next.arready = 1'b1;
        end
        if (state_reg.arready) begin
            state_next.arready = 1'b0;
            state_next.rvalid = 1'b1;
            state_next.rdata = 32'h0000_0000;
            state_next.rresp = cmi_pkg::RESP_SLVERR;
            for (int i = 0; i < 2; i++) begin
                if (rd_word == req_off(i)) begin
                    state_next.rresp = cmi_pkg::RESP_OKAY;
                    state_next.rdata[cmi_pkg::BUSY_BIT] = state_reg.sets[i].busy;
                    state_next.rdata[5:0] = state_reg.sets[i].msg_num;
                end
                if (rd_word == sel_off(i)) begin
                    state_next.rresp = cmi_pkg::RESP_OKAY;
                    state_next.rdata[7:0] = state_reg.sets[i].select;
                end
            end
        end
        if (state_reg.rvalid && RREADY) begin
            state_next.rvalid = 1'b0;
        end
    end

    // state register on the synchronised reset
    // the async clear uses the synchronised copy, so its release never races CLK
    always_ff @(posedge CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= '0;
            state_reg.sets[0].msg_num <= cmi_pkg::MSG_NUM_RST;
            state_reg.sets[1].msg_num <= cmi_pkg::MSG_NUM_RST;
            state_reg.sets[0].select <= cmi_pkg::SEL_RST;
            state_reg.sets[1].select <= cmi_pkg::SEL_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign AWREADY = state_reg.awready;
    assign WREADY = state_reg.wready;
    assign BVALID = state_reg.bvalid;
    assign BRESP = state_reg.bresp;
    assign ARREADY = state_reg.arready;
    assign RVALID = state_reg.rvalid;
    assign RRESP = state_reg.rresp;
    assign RDATA = state_reg.rdata;
    assign XFER_STB = state_reg.xfer_stb;
    assign XFER_SET = state_reg.xfer_set;
    assign XFER_OBJ = state_reg.xfer_obj;
    assign XFER_SELECT = state_reg.xfer_select;
    assign XFER_DONE = state_reg.xfer_done;

    // checks on the block's own behaviour
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n_reg);

    // request start and busy flag, set 1
    busy_set_a: assert property (req_start[0] |=> state_reg.sets[0].busy && XFER_STB)
        else $error("set 1 busy not raised by request write");

    busy_len_a: assert property ($rose(state_reg.sets[0].busy) |->
        state_reg.sets[0].busy[*4] ##1 !state_reg.sets[0].busy)
        else $error("set 1 busy length not four cycles");

    stb_cause_a: assert property (XFER_STB |-> $past(req_start) != 2'b00)
        else $error("transfer strobe without an accepted request");

    // busy only comes from a request, never from a software write of bit 15
    busy_only_a: assert property (!state_reg.sets[0].busy && !req_start[0] |=>
        !state_reg.sets[0].busy)
        else $error("set 1 busy raised without a request");

    busy_read_a: assert property (state_reg.arready &&
        rd_word == cmi_pkg::IF1_REQ_OFF |=> RDATA[15] == $past(state_reg.sets[0].busy))
        else $error("busy readback mismatch");

    done_pulse_a: assert property ($fell(state_reg.sets[0].busy) |-> XFER_DONE[0])
        else $error("done pulse missing");

    // set 2 runs the same logic; these keep the copy honest
    busy_window_a: assert property ($rose(state_reg.sets[1].busy) |->
        ##[3:6] !state_reg.sets[1].busy)
        else $error("set 2 busy outside three to six cycles");

    busy_set2_a: assert property (req_start[1] |=>
        state_reg.sets[1].busy && XFER_STB && XFER_SET)
        else $error("set 2 busy not raised by request write");

    done_pulse2_a: assert property ($fell(state_reg.sets[1].busy) |-> XFER_DONE[1])
        else $error("set 2 done pulse missing");

    busy_read2_a: assert property (state_reg.arready &&
        rd_word == cmi_pkg::IF2_REQ_OFF |=> RDATA[15] == $past(state_reg.sets[1].busy))
        else $error("set 2 busy readback mismatch");

    // a request landing while busy, even in the last busy cycle, must not restart
    busy_hold_a: assert property (req_hit[1] && state_reg.sets[1].busy |=>
        !XFER_STB && $stable(state_reg.sets[1].msg_num))
        else $error("request during busy disturbed set 2");

    // object number folding
    obj_range_a: assert property (XFER_STB |-> XFER_OBJ != 6'h00 && XFER_OBJ <= 6'h20)
        else $error("object number out of range");

    obj_direct_a: assert property (req_start[0] && WDATA[5:0] != 6'h00 &&
        WDATA[5:0] <= 6'h20 |=> XFER_OBJ == $past(WDATA[5:0]))
        else $error("valid number not passed through");

    obj_zero_a: assert property (req_start[0] && WDATA[5:0] == 6'h00 |=>
        XFER_OBJ == 6'h20)
        else $error("number zero not mapped to last object");

    obj_fold_a: assert property (req_start[1] && WDATA[5:0] > 6'h20 |=>
        XFER_OBJ == $past(WDATA[5:0]) - 6'h20)
        else $error("high number not folded");

    // direction and part selects
    select_copy_a: assert property (XFER_STB |->
        XFER_SELECT == state_reg.sets[XFER_SET].select)
        else $error("strobe carries wrong select");

    // the select a live transfer works from cannot be rewritten under it
    select_lock_a: assert property (state_reg.sets[0].busy |=>
        $stable(state_reg.sets[0].select))
        else $error("set 1 select changed while busy");

    select_lock2_a: assert property (state_reg.sets[1].busy |=>
        $stable(state_reg.sets[1].select))
        else $error("set 2 select changed while busy");

    both_busy_c: cover property (state_reg.sets[0].busy && state_reg.sets[1].busy);
    zero_num_c: cover property (req_start[0] && WDATA[5:0] == 6'h00);
    write_dir_c: cover property (XFER_STB && XFER_SELECT[cmi_pkg::DIR_BIT]);
    unmapped_c: cover property (BVALID && BRESP == cmi_pkg::RESP_SLVERR);
    fold_c: cover property (req_start[1] && WDATA[5:0] > 6'h20);

endmodule : cmi_transfer

`default_nettype wire

/* File: bench/cmi_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none

// message ram side: records each strobe and how long each set stays busy
module cmi_ram_model (
    input wire logic clk,
    input wire logic stb,
    input wire logic set,
    input wire logic [5:0] obj,
    input wire logic [7:0] sel,
    input wire logic [1:0] done,
    output logic last_set,
    output logic [5:0] last_obj,
    output logic [7:0] last_sel,
    output logic [1:0][3:0] span
);
    logic [1:0][3:0] cnt;

    // span counts the busy cycles, from the strobe cycle up to the one before done
    always_ff @(posedge clk) begin
        for (int s = 0; s < 2; s++) begin
            if (stb && set == s[0]) begin
                cnt[s] <= 4'h1;
            end else if (done[s]) begin
                span[s] <= cnt[s];
            end else begin
                cnt[s] <= cnt[s] + 4'h1;
            end
        end
        // object number and selects are only valid with the strobe
        if (stb) begin
            last_set <= set;
            last_obj <= obj;
            last_sel <= sel;
        end
    end
endmodule : cmi_ram_model

`default_nettype wire

/* File: bench/can_message_interface_transfer_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module can_message_interface_transfer_bench;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, RDATA;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, m_set, XFER_STB, XFER_SET;
    logic [1:0] BRESP, RRESP, XFER_DONE;
    logic [5:0] XFER_OBJ, m_obj;
    logic [7:0] XFER_SELECT, m_sel;
    logic [1:0][3:0] m_span;
    int mismatches = 0;
    int n_checks = 0;

    cmi_transfer dut_u (.CLK(CLK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .XFER_STB(XFER_STB), .XFER_SET(XFER_SET), .XFER_OBJ(XFER_OBJ),
        .XFER_SELECT(XFER_SELECT), .XFER_DONE(XFER_DONE));
    cmi_ram_model ram_u (.clk(CLK), .stb(XFER_STB), .set(XFER_SET), .obj(XFER_OBJ),
        .sel(XFER_SELECT), .done(XFER_DONE), .last_set(m_set), .last_obj(m_obj),
        .last_sel(m_sel), .span(m_span));

    always #10 CLK = ~CLK;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // each channel is released on the edge that takes it, never earlier
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        @(posedge CLK);
        {aw, w, b} = 3'b111;
        AWADDR <= a;
        WDATA <= d;
        {AWVALID, WVALID, BREADY} <= 3'b111;
        // no cycle limit here: a hung handshake is left to the watchdog
        while (aw || w || b) begin
            @(posedge CLK);
            if (aw && AWREADY) begin
                aw = 1'b0;
                AWVALID <= 1'b0;
            end
            if (w && WREADY) begin
                w = 1'b0;
                WVALID <= 1'b0;
            end
            if (b && BVALID) begin
                b = 1'b0;
                r = BRESP;
                BREADY <= 1'b0;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, rv;
        @(posedge CLK);
        {ar, rv} = 2'b11;
        ARADDR <= a;
        {ARVALID, RREADY} <= 2'b11;
        while (ar || rv) begin
            @(posedge CLK);
            if (ar && ARREADY) begin
                ar = 1'b0;
                ARVALID <= 1'b0;
            end
            if (rv && RVALID) begin
                rv = 1'b0;
                d = RDATA;
                r = RRESP;
                RREADY <= 1'b0;
            end
        end
    endtask : rd

    // bounded poll, so a stuck busy flag shows up as a mismatch and not a hang
    task automatic wait_idle(input logic [7:0] a, output logic [31:0] d);
        logic [1:0] r;
        d = 32'h8000;
        for (int n = 0; n < 20 && d[15] === 1'b1; n++) begin
            rd(a, d, r);
        end
    endtask : wait_idle

    task automatic t_reset;
        logic [7:0] a [4] = '{cmi_pkg::IF1_REQ_OFF, cmi_pkg::IF1_SEL_OFF,
            cmi_pkg::IF2_REQ_OFF, cmi_pkg::IF2_SEL_OFF};
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            rd(a[i], d, r);
            chk(d, (i % 2 == 0) ? 32'h1 : 32'h0);
            chk({30'h0, r}, {30'h0, cmi_pkg::RESP_OKAY});
        end
    endtask : t_reset

    // invalid numbers must still move the mapped object; busy write bit ignored
    task automatic t_map;
        logic [5:0] num [5] = '{6'h00, 6'h05, 6'h20, 6'h21, 6'h3f};
        logic [5:0] obj [5] = '{6'h20, 6'h05, 6'h20, 6'h01, 6'h1f};
        logic [7:0] sel [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h00};
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 5; i++) begin
            wr(cmi_pkg::IF1_SEL_OFF, {24'h0, sel[i]}, r);
            wr(cmi_pkg::IF1_REQ_OFF, {16'h0, 1'b1, 9'h0, num[i]}, r);
            rd(cmi_pkg::IF1_REQ_OFF, d, r);
            chk(d, {16'h0, 1'b1, 9'h0, num[i]});
            wait_idle(cmi_pkg::IF1_REQ_OFF, d);
            chk(d, {26'h0, num[i]});
            chk({26'h0, m_obj}, {26'h0, obj[i]});
            chk({23'h0, m_set, m_sel}, {24'h0, sel[i]});
            chk({31'h0, m_span[0] >= 4'h3 && m_span[0] <= 4'h6}, 32'h1);
        end
    endtask : t_map

    // second set runs on its own; its select is locked while busy
    task automatic t_set2;
        logic [31:0] d;
        logic [1:0] r;
        wr(cmi_pkg::IF2_SEL_OFF, 32'ha0, r);
        wr(cmi_pkg::IF2_REQ_OFF, 32'h27, r);
        wr(cmi_pkg::IF2_SEL_OFF, 32'hff, r);
        wait_idle(cmi_pkg::IF2_REQ_OFF, d);
        chk(d, 32'h27);
        rd(cmi_pkg::IF2_SEL_OFF, d, r);
        chk(d, 32'ha0);
        chk({23'h0, m_set, m_sel}, 32'h1a0);
        chk({26'h0, m_obj}, 32'h07);
        chk({31'h0, m_span[1] >= 4'h3 && m_span[1] <= 4'h6}, 32'h1);
        rd(cmi_pkg::IF1_REQ_OFF, d, r);
        chk(d, 32'h3f);
        wr(8'h40, 32'h1, r);
        chk({30'h0, r}, {30'h0, cmi_pkg::RESP_SLVERR});
        rd(8'h40, d, r);
        chk({r, d[29:0]}, {cmi_pkg::RESP_SLVERR, 30'h0});
        // a second request in the last busy cycle is answered but dropped
        wr(cmi_pkg::IF2_REQ_OFF, 32'h05, r);
        wr(cmi_pkg::IF2_REQ_OFF, 32'h33, r);
        chk({30'h0, r}, {30'h0, cmi_pkg::RESP_OKAY});
        wait_idle(cmi_pkg::IF2_REQ_OFF, d);
        chk(d, 32'h05);
        chk({26'h0, m_obj}, 32'h05);
    endtask : t_set2

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // the whole run needs well under 1000 cycles
    initial begin
        #50us;
        mismatches++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (3) @(posedge CLK);
        t_reset();
        t_map();
        t_set2();
        report_and_stop();
    end
endmodule : can_message_interface_transfer_bench

`default_nettype wire
